// *** hw/btfb_defines.vh ***
// Purpose: Shared constants of the bit-invert and flag-branch slice
// Assumes: 32-bit APB data, one word per register
// Notes:   Definitions only
`ifndef BTFB_DEFINES_VH
`define BTFB_DEFINES_VH

// ==========================================
// Register offsets (byte addresses)
`define BTFB_OFF_CTRL   12'h000
`define BTFB_OFF_BANK   12'h004
`define BTFB_OFF_FLAGS  12'h008
`define BTFB_OFF_PC     12'h00C
`define BTFB_OFF_INDEX  12'h010
`define BTFB_OFF_EXST   12'h014

// ==========================================
// Field positions
`define BTFB_CTRL_RUN   0
`define BTFB_CTRL_EXT   1
`define BTFB_FLAG_Z     0
`define BTFB_FLAG_OV    1
`define BTFB_EXST_ST    0
`define BTFB_EXST_KIND  3
`define BTFB_EXST_TAKEN 6
`define BTFB_EXST_IDX   7
`define BTFB_EXST_ADDR  8

// ==========================================
// Reset values
`define BTFB_RST_CTRL   2'h0
`define BTFB_RST_BANK   4'h0
`define BTFB_RST_FLAGS  2'h0
`define BTFB_RST_PC     21'h000000
`define BTFB_RST_INDEX  12'h000

// ==========================================
// Opcodes and addressing
`define BTFB_OPC_TOG    4'h7
`define BTFB_OPC_BOV    8'hE4
`define BTFB_OPC_BZ     8'hE0
`define BTFB_ACC_LIMIT  8'h5F
`define BTFB_ACC_HIBANK 4'hF
`define BTFB_ACC_LOBANK 4'h0
`define BTFB_PC_STEP    21'h000002

// ==========================================
// Quarter phases
`define BTFB_Q1         2'h0
`define BTFB_Q2         2'h1
`define BTFB_Q3         2'h2
`define BTFB_Q4         2'h3

`endif

// *** hw/btfb_operand.v ***
// Purpose: Operand address resolve and single-bit inversion
// Assumes: Pure combinational, fed from the instruction register
// Notes:   Used by btfb_core during the bit-invert instruction
`timescale 1ns/1ps
`default_nettype none
`include "btfb_defines.vh"

module btfb_operand (
   // Instruction and context
   input  wire [15:0] instr,
   input  wire [3:0]  bank_sel,
   input  wire [11:0] index_base,
   input  wire        ext_en,
   // Data path
   input  wire [7:0]  rdata,
   output reg  [11:0] addr,
   output wire [7:0]  wdata,
   output reg         idx_mode
);

   wire [7:0] fa   = instr[7:0];
   wire       abit = instr[8];
   wire [2:0] bsel = instr[11:9];

   // ==========================================
   // Address resolve
   always @* begin
      idx_mode = 1'b0;
      if (abit) begin
         addr = {bank_sel, fa};
      end else if (ext_en && fa <= `BTFB_ACC_LIMIT) begin
         idx_mode = 1'b1;
         addr = index_base + {4'h0, fa};
      end else if (fa <= `BTFB_ACC_LIMIT) begin
         addr = {`BTFB_ACC_LOBANK, fa};
      end else begin
         addr = {`BTFB_ACC_HIBANK, fa};
      end
   end

   // ==========================================
   // Invert only the chosen bit
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         assign wdata[i] = (bsel == i) ? ~rdata[i] : rdata[i];
      end
   endgenerate

endmodule
`default_nettype wire

// *** hw/btfb_core.v ***
// Purpose: Bit-invert and flag-branch execution slice with APB control
// Assumes: Program and data memory answer one cycle after their read strobe
// Notes:   One pclk per quarter phase, four per instruction cycle
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "btfb_defines.vh"

module btfb_core (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire [11:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Program memory
   output reg  [20:0] prog_addr,
   output reg         prog_rd,
   input  wire [15:0] prog_data,
   // Data memory
   output reg  [11:0] dmem_addr,
   output reg         dmem_rd,
   input  wire [7:0]  dmem_rdata,
   output reg  [7:0]  dmem_wdata,
   output reg         dmem_we
);

   // ==========================================
   // States and decode
   localparam [2:0] ST_STOP = 3'b001;
   localparam [2:0] ST_FILL = 3'b010;
   localparam [2:0] ST_EXEC = 3'b100;

   localparam [2:0] K_TOG = 3'b001;
   localparam [2:0] K_BOV = 3'b010;
   localparam [2:0] K_BZ  = 3'b100;

   // Anything outside the three is run as a no-op
   function [2:0] op_class;
      input [15:0] ir;
      begin
         if (ir[15:12] == `BTFB_OPC_TOG)
            op_class = K_TOG;
         else if (ir[15:8] == `BTFB_OPC_BOV)
            op_class = K_BOV;
         else if (ir[15:8] == `BTFB_OPC_BZ)
            op_class = K_BZ;
         else
            op_class = 3'h0;
      end
   endfunction

   function hit;
      input [11:0] a;
      input [11:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // ==========================================
   // Storage
   reg  [1:0]  ctrl_reg;
   reg  [3:0]  bank_select_reg;
   reg  [1:0]  flags_reg;
   reg  [11:0] index_reg;
   reg  [20:0] pc_reg;
   reg  [2:0]  state_reg;
   reg  [1:0]  q_reg;
   reg  [15:0] ir_reg;
   reg  [15:0] fetch_reg;
   reg  [2:0]  kind_reg;
   reg         taken_reg;
   reg         idx_last_reg;
   reg  [11:0] addr_last_reg;

   wire [11:0] res_addr;
   wire [7:0]  tog_data;
   wire        res_idx;

   wire run    = ctrl_reg[`BTFB_CTRL_RUN];
   wire ext_en = ctrl_reg[`BTFB_CTRL_EXT];
   wire f_z    = flags_reg[`BTFB_FLAG_Z];
   wire f_ov   = flags_reg[`BTFB_FLAG_OV];

   // Signed offset doubled, sign carried up to the PC width
   wire [20:0] br_off = {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
   wire [20:0] br_target = pc_reg + br_off;
   wire [20:0] pc_seq    = pc_reg + `BTFB_PC_STEP;

   // ==========================================
   // Operand path
   btfb_operand u_operand (
      .instr      (ir_reg),
      .bank_sel   (bank_select_reg),
      .index_base (index_reg),
      .ext_en     (ext_en),
      .rdata      (dmem_rdata),
      .addr       (res_addr),
      .wdata      (tog_data),
      .idx_mode   (res_idx)
   );

   // ==========================================
   // APB decode
   wire setup  = psel & ~penable;
   wire access = psel & penable & pready;
   wire wr_en  = access & pwrite;

   wire sel_ctrl  = hit(paddr, `BTFB_OFF_CTRL);
   wire sel_bank  = hit(paddr, `BTFB_OFF_BANK);
   wire sel_flags = hit(paddr, `BTFB_OFF_FLAGS);
   wire sel_pc    = hit(paddr, `BTFB_OFF_PC);
   wire sel_index = hit(paddr, `BTFB_OFF_INDEX);
   wire sel_exst  = hit(paddr, `BTFB_OFF_EXST);
   wire mapped    = sel_ctrl | sel_bank | sel_flags | sel_pc | sel_index | sel_exst;

   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      if (sel_ctrl)
         rd_mux[1:0] = ctrl_reg;
      if (sel_bank)
         rd_mux[3:0] = bank_select_reg;
      if (sel_flags)
         rd_mux[1:0] = flags_reg;
      if (sel_pc)
         rd_mux[20:0] = pc_reg;
      if (sel_index)
         rd_mux[11:0] = index_reg;
      if (sel_exst) begin
         rd_mux[`BTFB_EXST_ST +: 3]   = state_reg;
         rd_mux[`BTFB_EXST_KIND +: 3] = kind_reg;
         rd_mux[`BTFB_EXST_TAKEN]     = taken_reg;
         rd_mux[`BTFB_EXST_IDX]       = idx_last_reg;
         rd_mux[`BTFB_EXST_ADDR +: 12] = addr_last_reg;
      end
   end

   // Zero-wait answer: ready rises in the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup)
            prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
   end

   // ==========================================
   // Software registers
   // Flags are only written by software here; nothing in
   // this slice sets them, so no set/clear race exists
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg        <= `BTFB_RST_CTRL;
         bank_select_reg <= `BTFB_RST_BANK;
         flags_reg       <= `BTFB_RST_FLAGS;
         index_reg       <= `BTFB_RST_INDEX;
      end else if (wr_en) begin
         if (sel_ctrl)
            ctrl_reg <= pwdata[1:0];
         if (sel_bank)
            bank_select_reg <= pwdata[3:0];
         if (sel_flags)
            flags_reg <= pwdata[1:0];
         if (sel_index)
            index_reg <= pwdata[11:0];
      end
   end

   // ==========================================
   // Sequencer
   // Fetch of the next word overlaps execution of the current one,
   // so pc_reg already points past the executing word
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg     <= ST_STOP;
         q_reg         <= `BTFB_Q1;
         pc_reg        <= `BTFB_RST_PC;
         ir_reg        <= 16'h0000;
         fetch_reg     <= 16'h0000;
         kind_reg      <= 3'h0;
         taken_reg     <= 1'b0;
         idx_last_reg  <= 1'b0;
         addr_last_reg <= 12'h000;
         prog_addr     <= 21'h000000;
         prog_rd       <= 1'b0;
         dmem_addr     <= 12'h000;
         dmem_rd       <= 1'b0;
         dmem_wdata    <= 8'h00;
         dmem_we       <= 1'b0;
      end else begin
         prog_rd <= 1'b0;
         dmem_rd <= 1'b0;
         dmem_we <= 1'b0;
         case (state_reg)
            ST_STOP: begin
               q_reg <= `BTFB_Q1;
               // PC only moves under software while halted
               if (wr_en && sel_pc)
                  pc_reg <= {pwdata[20:1], 1'b0};
               if (run)
                  state_reg <= ST_FILL;
            end
            ST_FILL, ST_EXEC: begin
               q_reg <= q_reg + 2'h1;
               case (q_reg)
                  `BTFB_Q1: begin
                     // Decode; start fetch of the following word
                     prog_addr <= pc_reg;
                     prog_rd   <= 1'b1;
                     taken_reg <= 1'b0;
                     if (state_reg == ST_EXEC) begin
                        kind_reg <= op_class(ir_reg);
                        if (op_class(ir_reg) == K_TOG) begin
                           dmem_addr     <= res_addr;
                           dmem_rd       <= 1'b1;
                           addr_last_reg <= res_addr;
                           idx_last_reg  <= res_idx;
                        end
                     end else begin
                        kind_reg <= 3'h0;
                     end
                  end
                  `BTFB_Q2: begin
                     // Literal read; flag test
                     if (kind_reg == K_BOV)
                        taken_reg <= f_ov;
                     else if (kind_reg == K_BZ)
                        taken_reg <= f_z;
                     else
                        taken_reg <= 1'b0;
                  end
                  `BTFB_Q3: begin
                     // Modify; the flags stay untouched
                     fetch_reg <= prog_data;
                     if (kind_reg == K_TOG) begin
                        dmem_wdata <= tog_data;
                        dmem_we    <= 1'b1;
                     end
                  end
                  `BTFB_Q4: begin
                     // Write back data or PC
                     ir_reg <= fetch_reg;
                     if (taken_reg) begin
                        pc_reg    <= br_target;
                        state_reg <= ST_FILL;
                     end else if (!run) begin
                        // Keep pc at the fetched, unexecuted word
                        state_reg <= ST_STOP;
                     end else begin
                        pc_reg    <= pc_seq;
                        state_reg <= ST_EXEC;
                     end
                     if (!run)
                        state_reg <= ST_STOP;
                  end
                  default: begin
                     q_reg <= `BTFB_Q1;
                  end
               endcase
            end
            default: begin
               state_reg <= ST_STOP;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** dv/btfb_checker.sv ***
// Purpose: Checker for the bit-invert and flag-branch slice
// Assumes: Bank, flags, index and run change only by APB writes
// Notes:   Shadows software state to predict each data access and each fetch after the first of a run
`timescale 1ns/1ps
`default_nettype none
module btfb_checker (
   // Clock, reset, APB
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // Memories
   input wire logic [20:0] prog_addr,
   input wire logic        prog_rd,
   input wire logic [15:0] prog_data,
   input wire logic [11:0] dmem_addr,
   input wire logic        dmem_rd,
   input wire logic [7:0]  dmem_rdata,
   input wire logic [7:0]  dmem_wdata,
   input wire logic        dmem_we
);
   // ==========================================
   // Shadows; a discarded fetch is marked invalid so it never counts as executed
   logic [15:0] fw, exw;
   logic [20:0] fa, exa;
   logic [11:0] idx;
   logic [3:0]  bnk;
   logic [2:0]  bsel;
   logic [1:0]  flg;
   logic        fv, exv, pv, rd_d, run, ext;
   wire         wr = psel && penable && pready && pwrite;
   wire         tk = exv && ((exw[15:8] == 8'hE0 && flg[0]) || (exw[15:8] == 8'hE4 && flg[1]));
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {fw, exw, fa, exa, idx, bnk, bsel, flg, fv, exv, pv, rd_d, run, ext} <= '0;
      end else begin
         rd_d <= prog_rd;
         if (wr && paddr == 12'h000) {ext, run} <= pwdata[1:0];
         if (wr && paddr == 12'h004) bnk <= pwdata[3:0];
         if (wr && paddr == 12'h008) flg <= pwdata[1:0];
         if (wr && paddr == 12'h010) idx <= pwdata[11:0];
         if (dmem_rd) bsel <= fw[11:9];
         if (prog_rd) begin
            {exw, exv, exa, fa, pv} <= {fw, fv, fa, prog_addr, run};
         end
         if (rd_d) begin
            {fw, fv} <= {prog_data, !tk};
         end
         if (!run) begin
            {fv, pv} <= 2'h0;
         end
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rmw;
      ##1 $stable(dmem_addr) ##1 (dmem_we && $stable(dmem_addr));
   endsequence
   property p_rmw; dmem_rd |-> s_rmw; endproperty
   property p_gap; prog_rd |=> !prog_rd [*3]; endproperty
   property p_mask; dmem_we |-> (dmem_wdata ^ $past(dmem_rdata)) == (8'h01 << bsel); endproperty
   property p_opc; dmem_rd |-> prog_rd && fw[15:12] == 4'h7; endproperty
   property p_bank; dmem_rd && fw[8] |-> dmem_addr == {bnk, fw[7:0]}; endproperty
   property p_acc;
      dmem_rd && !fw[8] && !(ext && fw[7:0] <= 8'h5F) |-> dmem_addr == {((fw[7:0] > 8'h5F) ? 4'hF : 4'h0), fw[7:0]};
   endproperty
   property p_idx; dmem_rd && !fw[8] && ext && fw[7:0] <= 8'h5F |-> dmem_addr == idx + fw[7:0]; endproperty
   property p_taken; prog_rd && pv && tk |-> prog_addr == exa + 21'h2 + {{12{exw[7]}}, exw[7:0], 1'b0}; endproperty
   property p_seq; prog_rd && pv && !tk |-> prog_addr == fa + 21'h2; endproperty
   property p_fill; rd_d && tk |=> (!dmem_rd && !dmem_we) [*5]; endproperty
   a_rmw: assert property (p_rmw) else $error("write not two cycles after read");
   a_gap: assert property (p_gap) else $error("fetch closer than four cycles");
   a_mask: assert property (p_mask) else $error("wrong bit inverted");
   a_opc: assert property (p_opc) else $error("data read outside invert");
   a_bank: assert property (p_bank) else $error("bank address wrong");
   a_acc: assert property (p_acc) else $error("access bank address wrong");
   a_idx: assert property (p_idx) else $error("indexed address wrong");
   a_taken: assert property (p_taken) else $error("branch target wrong");
   a_seq: assert property (p_seq) else $error("sequential fetch wrong");
   a_fill: assert property (p_fill) else $error("data access in fill cycle");
endmodule
bind btfb_core btfb_checker i_btfb_checker (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prog_addr(prog_addr),
   .prog_rd(prog_rd), .prog_data(prog_data), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
   .dmem_rdata(dmem_rdata), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we));
`default_nettype wire

// *** dv/btfb_mem_model.sv ***
// Purpose: Program and data memory beside the slice
// Assumes: One-cycle read latency
// Notes:   Words outside a program are no-op filler
`timescale 1ns/1ps
`default_nettype none
module btfb_mem_model (
   input  wire logic        pclk,
   input  wire logic [20:0] prog_addr,
   input  wire logic        prog_rd,
   output var  logic [15:0] prog_data,
   input  wire logic [11:0] dmem_addr,
   input  wire logic        dmem_rd,
   output var  logic [7:0]  dmem_rdata,
   input  wire logic [7:0]  dmem_wdata,
   input  wire logic        dmem_we
);
   logic [15:0] prog [0:255];
   logic [7:0]  dmem [0:4095];
   initial begin
      prog_data = 16'h0000;
      dmem_rdata = 8'h00;
      for (int i = 0; i < 256; i++) prog[i] = 16'hFFFF;
   end
   // Stale data is inverted every cycle, so a sample one cycle late sees the old value inverted
   always @(posedge pclk) begin
      prog_data <= prog_rd ? prog[prog_addr[8:1]] : ~prog_data;
      dmem_rdata <= dmem_rd ? dmem[dmem_addr] : ~dmem_rdata;
      if (dmem_we) dmem[dmem_addr] <= dmem_wdata;
   end
endmodule
`default_nettype wire

// *** dv/bit_toggle_and_flag_branch_exec_bench.sv ***
// Purpose: Self-checking bench for the bit-invert and flag-branch slice
// Assumes: Programs are loaded only while the slice is stopped
// Notes:   Expected writes and reads are queued and matched by a monitor
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_and_flag_branch_exec_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, prog_rd, dmem_rd, dmem_we;
   logic [11:0] paddr, dmem_addr, idx;
   logic [31:0] pwdata, prdata;
   logic [20:0] prog_addr;
   logic [15:0] prog_data;
   logic [7:0]  dmem_rdata, dmem_wdata;
   logic [3:0]  bnk;
   logic [31:0] rq [$];
   logic [19:0] wq [$];
   logic [11:0] rst_a [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
   logic [31:0] rst_v [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h80000000};
   int          bad_count, checks, pc;
   btfb_core i_btfb_core (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data), .dmem_addr(dmem_addr),
      .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we));
   btfb_mem_model i_btfb_mem_model (.pclk(pclk), .prog_addr(prog_addr), .prog_rd(prog_rd),
      .prog_data(prog_data), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata),
      .dmem_wdata(dmem_wdata), .dmem_we(dmem_we));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // ==========================================
   // Tasks
   task cmp(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task give_up;
      bad_count++;
      conclude();
   endtask
   // Top bit of an expectation is the error flag
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
      int n;
      rq.push_back(e);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 50);
      if (!pready) give_up();
      {psel, penable} <= 2'h0;
      @(posedge pclk);
   endtask
   task put(input logic [15:0] w);
      i_btfb_mem_model.prog[pc] = w;
      pc++;
   endtask
   task inv(input logic a, input logic [7:0] f, input logic [11:0] da);
      logic [2:0] b;
      logic [7:0] v;
      b = $urandom;
      v = $urandom;
      i_btfb_mem_model.dmem[da] = v;
      wq.push_back({da, v ^ (8'h01 << b)});
      put({4'h7, b, a, f});
   endtask
   // Halt is a branch onto itself, so the stopped PC is known
   task run_prog(input logic [31:0] ctrl, input logic [31:0] flags, input logic [31:0] halt);
      int n;
      apb(12'h000, 1'b1, ctrl, 32'h0);
      n = 0;
      while (wq.size() > 0 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 3000) give_up();
      repeat (16) @(posedge pclk);
      apb(12'h000, 1'b1, ctrl & 32'h2, 32'h0);
      repeat (4) @(posedge pclk);
      apb(12'h00C, 1'b0, 32'h0, halt);
      apb(12'h008, 1'b0, 32'h0, flags);
      $display("program ending at %h done", halt);
   endtask
   // ==========================================
   // Monitor
   always @(posedge pclk) begin
      if (psel && penable && pready)
         cmp({pslverr, pwrite ? 31'h0 : prdata[30:0]}, rq.pop_front());
      if (dmem_we)
         cmp({12'h0, dmem_addr, dmem_wdata}, wq.size() > 0 ? {12'h0, wq.pop_front()} : 32'hFFFFFFFF);
   end
   // ==========================================
   // Sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      bad_count = 0;
      checks = 0;
      void'($urandom(32'h0135b8bc));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rst_a[i]) apb(rst_a[i], 1'b0, 32'h0, rst_v[i]);
      apb(12'h018, 1'b1, 32'hFFFFFFFF, 32'h80000000);
      apb(12'h000, 1'b0, 32'h0, 32'h0);
      $display("reset values done");
      bnk = $urandom;
      apb(12'h004, 1'b1, {28'h0, bnk}, 32'h0);
      apb(12'h008, 1'b1, 32'h1, 32'h0);
      pc = 0;
      inv(1'b1, 8'h10, {bnk, 8'h10});
      inv(1'b0, 8'h20, 12'h020);
      inv(1'b0, 8'h5F, 12'h05F);
      inv(1'b0, 8'h80, 12'hF80);
      put(16'hE403);
      put(16'hE001);
      put(16'h7E10);
      inv(1'b1, 8'hFF, {bnk, 8'hFF});
      put(16'hE0FF);
      run_prog(32'h1, 32'h1, 32'h10);
      idx = ($urandom & 12'h0F0) | 12'h100;
      apb(12'h010, 1'b1, {20'h0, idx}, 32'h0);
      apb(12'h008, 1'b1, 32'h2, 32'h0);
      apb(12'h00C, 1'b1, 32'h40, 32'h0);
      pc = 32;
      inv(1'b0, 8'h5F, idx + 12'h05F);
      inv(1'b0, 8'h00, idx);
      inv(1'b0, 8'h60, 12'hF60);
      inv(1'b1, 8'h33, {bnk, 8'h33});
      put(16'hE07F);
      put(16'hE402);
      put(16'h7010);
      put(16'h7020);
      inv(1'b1, 8'h44, {bnk, 8'h44});
      put(16'hE4FF);
      run_prog(32'h3, 32'h2, 32'h52);
      pc = 1;
      inv(1'b1, 8'h77, {bnk, 8'h77});
      put(16'hE0FF);
      pc = 128;
      put(16'hE080);
      apb(12'h008, 1'b1, 32'h1, 32'h0);
      apb(12'h00C, 1'b1, 32'h100, 32'h0);
      run_prog(32'h1, 32'h1, 32'h4);
      conclude();
   end
endmodule
`default_nettype wire
